/* File: core/disk_cfg_regs.sv */
// Local microcontroller register block: strobes, jumpers, drive link, AT control
`timescale 1ns/10ps
`default_nettype none
module disk_cfg_regs
    import disk_cfg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive pins, asynchronous
    input wire logic drive_ready_in,
    input wire logic write_fault_in,
    input wire logic index_in,
    input wire logic sector_pulse_in,
    input wire logic read_run_in,
    input wire logic [BUF_ADDR_W-1:0] buf_addr_in,
    // Event and state inputs from controller logic
    input wire logic at_mode_in,
    input wire logic fifo_err_set_in,
    input wire logic hw_busy_set_in,
    input wire logic host_busy_set_in,
    input wire logic host_ptr_set_in,
    input wire logic disk_req_set_in,
    input wire logic cmd_sel_set_in,
    input wire logic host_soft_reset_in,
    input wire logic cmd_start_in,
    input wire logic sector_done_in,
    input wire logic [7:0] sector_num_in,
    input wire logic [7:0] select_drive_head_reg_in,
    input wire logic [7:0] host_status_in,
    input wire logic seven_ecc_bytes_sel_in,
    input wire logic [7:0] ram_rdata_in,
    // Flags
    output logic fifo_err_flag_out,
    output logic hw_busy_flag_out,
    output logic host_busy_flag_out,
    output logic host_ptr_flag_out,
    output logic disk_data_req_irq_out,
    output logic cmd_sel_flag_out,
    // Drive controller control
    output logic hold_drive_ctrl_reset_out,
    output logic micro_ram_path_en_out,
    output logic taskfile_blocked_out,
    output logic sector_compare_bypass_out,
    output logic soft_reset_irq_out,
    output logic board_reset_out,
    output logic drive_ready_out,
    output logic write_fault_out,
    output logic index_out,
    output logic sector_pulse_out,
    output logic read_run_out,
    // Buffer RAM path
    output logic ram_wr_stb_out,
    output logic ram_rd_stb_out,
    output logic [7:0] ram_wdata_out,
    // AT logic
    output logic auto_request_en_out,
    output logic seven_ecc_sel_out,
    output logic [7:0] host_status_out,
    output logic [7:0] last_sector_out
);
    localparam int SYNC_W = BUF_ADDR_W + 5;

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [7:0] link_ctrl_q;
    logic [7:0] at_ctrl_q;
    logic [7:0] drv0_status_q;
    logic [7:0] drv1_status_q;
    logic [7:0] last_sector_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [9:0] idx;
    logic aligned;
    logic hit;
    logic wr_en;
    logic rd_en;
    logic [7:0] rdata_d;
    logic [7:0] strobe;
    logic polarity;
    logic drive_ready_in_act;
    logic wf_act;
    logic host_drive;
    logic fifo_err_q;
    logic hw_busy_q;
    logic host_busy_q;
    logic host_ptr_q;
    logic disk_req_q;
    logic cmd_sel_q;

    // Pins pass two flops before any logic looks at them
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {buf_addr_in, read_run_in, sector_pulse_in, index_in,
                        write_fault_in, drive_ready_in};
            sync2_q <= sync1_q;
        end
    end

    assign polarity = link_ctrl_q[LNK_POLARITY];
    assign drive_ready_in_act = polarity ? sync2_q[0] : ~sync2_q[0];
    assign wf_act = polarity ? sync2_q[1] : ~sync2_q[1];
    assign host_drive = select_drive_head_reg_in[SDH_DRIVE_BIT];

    // APB decode; one wait state so read data comes from a flop
    assign idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit = aligned && (idx == IDX_AT_CTRL || idx == IDX_RAM_PORT ||
        idx == IDX_STROBE || idx == IDX_CFG_LOW || idx == IDX_CFG_HIGH ||
        idx == IDX_LINK || idx == IDX_LAST_SECTOR || idx == IDX_DRV0_STATUS ||
        idx == IDX_DRV1_STATUS);
    assign wr_en = psel && penable && pready_q && pwrite && hit;
    assign rd_en = psel && penable && pready_q && !pwrite && hit;
    // Strobe bits are pulses; nothing of them is stored
    assign strobe = (wr_en && idx == IDX_STROBE) ? pwdata[7:0] : 8'h00;

    always_comb begin
        rdata_d = 8'h00;
        unique case (idx)
            IDX_AT_CTRL: rdata_d = at_ctrl_q;
            IDX_RAM_PORT: rdata_d = link_ctrl_q[LNK_RAM_PATH] ? ram_rdata_in : 8'h00;
            IDX_CFG_LOW: rdata_d = sync2_q[12:5];
            IDX_CFG_HIGH: rdata_d = {1'b0, sync2_q[19:13]};
            IDX_LINK: rdata_d = {link_ctrl_q[LNK_HOLD_RESET], drive_ready_in_act, wf_act,
                                 host_drive, link_ctrl_q[3:0]};
            IDX_LAST_SECTOR: rdata_d = last_sector_q;
            IDX_DRV0_STATUS: rdata_d = drv0_status_q;
            IDX_DRV1_STATUS: rdata_d = drv1_status_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= psel && penable && !pready_q;
            if (psel && penable && !pready_q) begin
                pslverr_q <= !hit;
                prdata_q <= (hit && !pwrite) ? {24'h000000, rdata_d} : 32'h00000000;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // Control registers; reserved bits store zero
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            link_ctrl_q <= REG_RESET;
            at_ctrl_q <= REG_RESET;
            drv0_status_q <= REG_RESET;
            drv1_status_q <= REG_RESET;
        end else if (wr_en) begin
            if (idx == IDX_LINK) link_ctrl_q <= pwdata[7:0] & LNK_CTRL_MASK;
            if (idx == IDX_AT_CTRL) at_ctrl_q <= pwdata[7:0] & AT_CTRL_MASK;
            if (idx == IDX_DRV0_STATUS) drv0_status_q <= pwdata[7:0];
            if (idx == IDX_DRV1_STATUS) drv1_status_q <= pwdata[7:0];
        end
    end

    // Flags: an event in the clearing cycle wins over the clear
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fifo_err_q <= 1'b0;
            hw_busy_q <= 1'b0;
            host_busy_q <= 1'b0;
            host_ptr_q <= 1'b0;
            disk_req_q <= 1'b0;
            cmd_sel_q <= 1'b0;
        end else begin
            fifo_err_q <= fifo_err_set_in || (fifo_err_q && !strobe[STB_FIFO_ERR]);
            hw_busy_q <= hw_busy_set_in ||
                (hw_busy_q && !(strobe[STB_BUSY] && !at_mode_in));
            host_busy_q <= host_busy_set_in ||
                (host_busy_q && !(strobe[STB_BUSY] && at_mode_in));
            host_ptr_q <= host_ptr_set_in || (host_ptr_q && !strobe[STB_HOST_PTR]);
            disk_req_q <= disk_req_set_in || (disk_req_q && !strobe[STB_DISK_REQ]);
            cmd_sel_q <= cmd_sel_set_in || (cmd_sel_q && !strobe[STB_CMD_SEL]);
        end
    end

    // Last sector capture; a new command outranks a late sector report
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            last_sector_q <= LAST_SECTOR_START;
        end else if (cmd_start_in) begin
            last_sector_q <= LAST_SECTOR_START;
        end else if (sector_done_in) begin
            last_sector_q <= sector_num_in;
        end
    end

    // Registered outputs toward the drive controller, buffer and host logic
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_drive_ctrl_reset_out <= 1'b0;
            micro_ram_path_en_out <= 1'b0;
            taskfile_blocked_out <= 1'b0;
            sector_compare_bypass_out <= 1'b0;
            soft_reset_irq_out <= 1'b0;
            board_reset_out <= 1'b0;
            drive_ready_out <= 1'b0;
            write_fault_out <= 1'b0;
            index_out <= 1'b0;
            sector_pulse_out <= 1'b0;
            read_run_out <= 1'b0;
            ram_wr_stb_out <= 1'b0;
            ram_rd_stb_out <= 1'b0;
            ram_wdata_out <= 8'h00;
            auto_request_en_out <= 1'b0;
            seven_ecc_sel_out <= 1'b0;
            host_status_out <= 8'h00;
        end else begin
            hold_drive_ctrl_reset_out <= link_ctrl_q[LNK_HOLD_RESET];
            micro_ram_path_en_out <= link_ctrl_q[LNK_RAM_PATH];
            taskfile_blocked_out <= link_ctrl_q[LNK_RAM_PATH];
            sector_compare_bypass_out <= link_ctrl_q[LNK_CMP_BYPASS];
            // The interrupt always fires; the board reset only when not blocked
            soft_reset_irq_out <= host_soft_reset_in;
            board_reset_out <= host_soft_reset_in && !link_ctrl_q[LNK_RST_BLOCK];
            drive_ready_out <= drive_ready_in_act;
            write_fault_out <= wf_act;
            index_out <= polarity ? sync2_q[2] : ~sync2_q[2];
            sector_pulse_out <= polarity ? sync2_q[3] : ~sync2_q[3];
            read_run_out <= sync2_q[4];
            ram_wr_stb_out <= wr_en && idx == IDX_RAM_PORT && link_ctrl_q[LNK_RAM_PATH];
            ram_rd_stb_out <= rd_en && idx == IDX_RAM_PORT && link_ctrl_q[LNK_RAM_PATH];
            if (wr_en && idx == IDX_RAM_PORT) ram_wdata_out <= pwdata[7:0];
            auto_request_en_out <= at_ctrl_q[AT_AUTO_REQ] && at_mode_in;
            seven_ecc_sel_out <= at_ctrl_q[AT_AUTO_REQ] ? at_ctrl_q[AT_SEVEN_ECC]
                                                        : seven_ecc_bytes_sel_in;
            host_status_out <= (host_status_in & ~HOST_STATUS_MASK) |
                ((host_drive ? drv1_status_q : drv0_status_q) & HOST_STATUS_MASK);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign fifo_err_flag_out = fifo_err_q;
    assign hw_busy_flag_out = hw_busy_q;
    assign host_busy_flag_out = host_busy_q;
    assign host_ptr_flag_out = host_ptr_q;
    assign disk_data_req_irq_out = disk_req_q;
    assign cmd_sel_flag_out = cmd_sel_q;
    assign last_sector_out = last_sector_q;

    // Flag checks allow a set event to win over the clear in the same cycle
    AST_FIFO_CLR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        strobe[STB_FIFO_ERR] && !fifo_err_set_in |=> !fifo_err_flag_out)
        else $error("FIFO error flag not cleared");
    AST_FIFO_SET: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        fifo_err_set_in |=> fifo_err_flag_out)
        else $error("FIFO error event lost");
    AST_BUSY_MODE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        strobe[STB_BUSY] && at_mode_in && !hw_busy_set_in |=>
        hw_busy_flag_out == $past(hw_busy_q))
        else $error("Hardware busy touched in AT mode");
    AST_HW_BUSY_CLR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        strobe[STB_BUSY] && !at_mode_in && !hw_busy_set_in |=> !hw_busy_flag_out)
        else $error("Hardware busy not cleared in XT mode");
    AST_HOST_BUSY_CLR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        strobe[STB_BUSY] && at_mode_in && !host_busy_set_in |=> !host_busy_flag_out)
        else $error("Host busy not cleared in AT mode");
    AST_HOST_BUSY_XT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        strobe[STB_BUSY] && !at_mode_in && !host_busy_set_in |=>
        host_busy_flag_out == $past(host_busy_q))
        else $error("Host busy touched in XT mode");
    AST_HOST_PTR_CLR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        strobe[STB_HOST_PTR] && !host_ptr_set_in |=> !host_ptr_flag_out)
        else $error("Host pointer flag not cleared");
    AST_DISK_REQ_CLR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        strobe[STB_DISK_REQ] && !disk_req_set_in |=> !disk_data_req_irq_out)
        else $error("Disk request flag not cleared");
    AST_CMD_SEL_KEEP: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        cmd_sel_flag_out && !strobe[STB_CMD_SEL] |=> cmd_sel_flag_out)
        else $error("Command flag lost without strobe");
    AST_HOLD_RESET: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        wr_en && idx == IDX_LINK && pwdata[7] |=> ##1 hold_drive_ctrl_reset_out)
        else $error("Drive controller reset not held");
    AST_RAM_STB_GATE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        ram_wr_stb_out || ram_rd_stb_out |-> micro_ram_path_en_out)
        else $error("Buffer RAM strobe while RAM path closed");
    AST_SOFT_RESET: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        host_soft_reset_in && link_ctrl_q[LNK_RST_BLOCK] |=>
        soft_reset_irq_out && !board_reset_out)
        else $error("Soft reset not redirected");
    AST_CMP_BYPASS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        1'b1 |=> sector_compare_bypass_out == $past(link_ctrl_q[LNK_CMP_BYPASS]))
        else $error("Compare bypass does not follow control bit");
    AST_LAST_SECTOR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        cmd_start_in |=> last_sector_out == LAST_SECTOR_START)
        else $error("Last sector not preset at command start");
    AST_SECTOR_CAP: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        sector_done_in && !cmd_start_in |=> last_sector_out == $past(sector_num_in))
        else $error("Last sector not captured");
    AST_HOST_STATUS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !host_drive |=> (host_status_out & HOST_STATUS_MASK) ==
        ($past(drv0_status_q) & HOST_STATUS_MASK))
        else $error("Host status not from drive zero");
    AST_HOST_ONE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        host_drive |=> (host_status_out & HOST_STATUS_MASK) ==
        ($past(drv1_status_q) & HOST_STATUS_MASK))
        else $error("Host status not from drive one");
    AST_HOST_KEEP: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        1'b1 |=> (host_status_out & ~HOST_STATUS_MASK) ==
        ($past(host_status_in) & ~HOST_STATUS_MASK))
        else $error("Host status bits outside the mask altered");
    AST_ECC_SEL: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !at_ctrl_q[AT_AUTO_REQ] |=> seven_ecc_sel_out == $past(seven_ecc_bytes_sel_in))
        else $error("ECC length not from fixed disk bit");
endmodule
`default_nettype wire

/* File: core/disk_cfg_pkg.sv */
// Package: register indices, field positions and reset values of the local register block
package disk_cfg_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_AT_CTRL = 10'h02A;
    localparam logic [9:0] IDX_RAM_PORT = 10'h036;
    localparam logic [9:0] IDX_STROBE = 10'h038;
    localparam logic [9:0] IDX_CFG_LOW = 10'h039;
    localparam logic [9:0] IDX_CFG_HIGH = 10'h03A;
    localparam logic [9:0] IDX_LINK = 10'h03B;
    localparam logic [9:0] IDX_LAST_SECTOR = 10'h03C;
    localparam logic [9:0] IDX_DRV0_STATUS = 10'h03D;
    localparam logic [9:0] IDX_DRV1_STATUS = 10'h03E;
    // Strobe register bits
    localparam int STB_FIFO_ERR = 4;
    localparam int STB_BUSY = 3;
    localparam int STB_HOST_PTR = 2;
    localparam int STB_DISK_REQ = 1;
    localparam int STB_CMD_SEL = 0;
    // Drive link control and status bits
    localparam int LNK_HOLD_RESET = 7;
    localparam int LNK_DRIVE_READY = 6;
    localparam int LNK_WRITE_FAULT = 5;
    localparam int LNK_HOST_DRIVE = 4;
    localparam int LNK_RAM_PATH = 3;
    localparam int LNK_RST_BLOCK = 2;
    localparam int LNK_POLARITY = 1;
    localparam int LNK_CMP_BYPASS = 0;
    // Bits of the link control register that are stored
    localparam logic [7:0] LNK_CTRL_MASK = 8'h8F;
    // Select/drive/head copy bit that picks the drive
    localparam int SDH_DRIVE_BIT = 4;
    // AT control bits
    localparam int AT_AUTO_REQ = 0;
    localparam int AT_SEVEN_ECC = 1;
    localparam logic [7:0] AT_CTRL_MASK = 8'h03;
    // Host status bits taken from the drive status registers
    localparam logic [7:0] HOST_STATUS_MASK = 8'h75;
    // Reset and start-of-command values
    localparam logic [7:0] LAST_SECTOR_START = 8'hFF;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int BUF_ADDR_W = 15;
endpackage

/* File: dv/micro_model.sv */
// APB master model of the local microcontroller
`timescale 1ns/10ps
`default_nettype none
module micro_model (
    // Clock
    input wire logic ref_clk_in,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // Request held until pready is seen high at an edge
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge ref_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        do @(posedge ref_clk_in); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show the inverse so stale values are never trusted
        paddr <= ~addr;
        pwdata <= ~wd;
    endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking testbench of the local register block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import disk_cfg_pkg::*;
    logic ref_clk_in, sys_rst_in, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic drive_ready_in, write_fault_in, at_mode_in, host_soft_reset_in, cmd_start_in;
    logic sector_done_in, seven_ecc_bytes_sel_in, drive_ready_out, board_reset_out;
    logic soft_reset_irq_out, auto_request_en_out, seven_ecc_sel_out, ram_wr_stb_out;
    logic hold_drive_ctrl_reset_out, micro_ram_path_en_out, taskfile_blocked_out;
    logic sector_compare_bypass_out;
    logic [14:0] buf_addr_in;
    logic [7:0] sector_num_in, select_drive_head_reg_in, host_status_in, ram_rdata_in;
    logic [7:0] ram_wdata_out, host_status_out, ram_seen, v;
    logic [5:0] set_v, ef, at_t [4];
    wire [5:0] flg;
    logic [32:0] exp_q [$];
    int n_fail, n_tests, cyc;

    micro_model i_micro (.ref_clk_in, .psel, .penable, .pwrite, .paddr, .pwdata, .pready);
    disk_cfg_regs i_dut (.ref_clk_in, .sys_rst_in, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .drive_ready_in, .write_fault_in, .index_in(1'b0),
        .sector_pulse_in(1'b0), .read_run_in(1'b0), .buf_addr_in, .at_mode_in,
        .fifo_err_set_in(set_v[5]), .hw_busy_set_in(set_v[4]), .host_busy_set_in(set_v[3]),
        .host_ptr_set_in(set_v[2]), .disk_req_set_in(set_v[1]), .cmd_sel_set_in(set_v[0]),
        .host_soft_reset_in, .cmd_start_in, .sector_done_in, .sector_num_in,
        .select_drive_head_reg_in, .host_status_in, .seven_ecc_bytes_sel_in, .ram_rdata_in,
        .fifo_err_flag_out(flg[5]), .hw_busy_flag_out(flg[4]), .host_busy_flag_out(flg[3]),
        .host_ptr_flag_out(flg[2]), .disk_data_req_irq_out(flg[1]), .cmd_sel_flag_out(flg[0]),
        .hold_drive_ctrl_reset_out, .micro_ram_path_en_out, .taskfile_blocked_out,
        .sector_compare_bypass_out, .soft_reset_irq_out, .board_reset_out, .drive_ready_out,
        .write_fault_out(), .index_out(), .sector_pulse_out(), .read_run_out(),
        .ram_wr_stb_out, .ram_rd_stb_out(), .ram_wdata_out, .auto_request_en_out,
        .seven_ecc_sel_out, .host_status_out, .last_sector_out());

    always #2 ref_clk_in = ~ref_clk_in;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input string what, input logic [32:0] s, input logic [32:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic rd(input logic [9:0] i, input logic [32:0] e);
        exp_q.push_back(e);
        i_micro.xfer(1'b0, {i, 2'b00}, 32'h0);
    endtask

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        i_micro.xfer(1'b1, {i, 2'b00}, {24'h0, d});
    endtask

    task automatic srst(input logic blk);
        @(posedge ref_clk_in) host_soft_reset_in <= 1'b1;
        @(posedge ref_clk_in) host_soft_reset_in <= 1'b0;
        #1;
        cmp("board_reset", {32'h0, board_reset_out}, {32'h0, !blk});
        cmp("soft_irq", {32'h0, soft_reset_irq_out}, 33'h1);
    endtask

    // Read results are matched against the oldest note when pready shows
    always @(posedge ref_clk_in) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            cmp("read", {pslverr, prdata}, exp_q.pop_front());
        end
    end

    always @(posedge ref_clk_in) begin
        if (ram_wr_stb_out === 1'b1) ram_seen <= ram_wdata_out;
    end

    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        {ref_clk_in, drive_ready_in, write_fault_in, at_mode_in} = 4'h0;
        {host_soft_reset_in, cmd_start_in, sector_done_in, seven_ecc_bytes_sel_in} = 4'h0;
        {buf_addr_in, sector_num_in, host_status_in, ram_rdata_in, ram_seen} = 47'h0;
        select_drive_head_reg_in = 8'h00;
        set_v = 6'h00;
        at_t = '{6'b101111, 6'b100110, 6'b110001, 6'b000100};
        rnd = 32'h00017A67;
        sys_rst_in = 1'b1;
        repeat (3) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rd(IDX_AT_CTRL, 33'h0);
        rd(IDX_DRV0_STATUS, 33'h0);
        rd(IDX_LAST_SECTOR, {25'h0, LAST_SECTOR_START});
        // Misaligned read: error response and no data
        exp_q.push_back(33'h100000000);
        i_micro.xfer(1'b0, 12'h0A9, 32'h0);
        rd(10'h000, 33'h100000000);
        for (int m = 0; m < 2; m++) begin
            at_mode_in <= m[0];
            for (int b = 0; b < 5; b++) begin
                @(posedge ref_clk_in) set_v <= 6'h3F;
                @(posedge ref_clk_in) set_v <= 6'h00;
                ef = 6'h3F;
                ef[b == 4 ? 5 : (b == 3 ? (m ? 3 : 4) : b)] = 1'b0;
                // Busy clear in AT mode only as the closing step of a command
                wr(IDX_STROBE, 8'h01 << b);
                wt(2);
                cmp("flags", {27'h0, flg}, {27'h0, ef});
            end
        end
        rd(IDX_STROBE, 33'h0);
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            {drive_ready_in, write_fault_in, select_drive_head_reg_in} <= rnd[17:8];
            ram_rdata_in <= rnd[23:16];
            v = {rnd[7], 3'h0, k[0], 1'b0, k[0], rnd[0]};
            // Buffer direction is settled elsewhere before the RAM path opens
            wr(IDX_LINK, v);
            wt(5);
            cmp("ctl", {29'h0, hold_drive_ctrl_reset_out, micro_ram_path_en_out,
                taskfile_blocked_out, sector_compare_bypass_out},
                {29'h0, v[7], v[3], v[3], v[0]});
            cmp("ready", {32'h0, drive_ready_out}, {32'h0, drive_ready_in ^ !v[1]});
            rd(IDX_LINK, {25'h0, v[7], drive_ready_in ^ !v[1], write_fault_in ^ !v[1],
                select_drive_head_reg_in[4], v[3:0]});
            rd(IDX_RAM_PORT, {25'h0, k ? rnd[23:16] : 8'h00});
            wr(IDX_RAM_PORT, rnd[31:24]);
            wt(3);
            cmp("ram_wr", {25'h0, ram_seen}, {25'h0, k ? rnd[31:24] : 8'h00});
        end
        srst(1'b0);
        wr(IDX_LINK, 8'h04);
        wt(3);
        srst(1'b1);
        buf_addr_in <= rnd[14:0];
        repeat (25000) @(posedge ref_clk_in);
        rd(IDX_CFG_LOW, {25'h0, buf_addr_in[7:0]});
        rd(IDX_CFG_HIGH, {25'h0, 1'b0, buf_addr_in[14:8]});
        @(posedge ref_clk_in) cmd_start_in <= 1'b1;
        @(posedge ref_clk_in) begin
            cmd_start_in <= 1'b0;
            sector_done_in <= 1'b1;
            sector_num_in <= rnd[7:0];
        end
        @(posedge ref_clk_in) sector_done_in <= 1'b0;
        rd(IDX_LAST_SECTOR, {25'h0, rnd[7:0]});
        @(posedge ref_clk_in) cmd_start_in <= 1'b1;
        @(posedge ref_clk_in) cmd_start_in <= 1'b0;
        rd(IDX_LAST_SECTOR, {25'h0, LAST_SECTOR_START});
        for (int t = 0; t < 4; t++) begin
            {at_mode_in, seven_ecc_bytes_sel_in} <= at_t[t][5:4];
            wr(IDX_AT_CTRL, {6'h3F, at_t[t][3:2]});
            rd(IDX_AT_CTRL, {31'h0, at_t[t][3:2]});
            wt(3);
            cmp("at", {31'h0, auto_request_en_out, seven_ecc_sel_out},
                {31'h0, at_t[t][1:0]});
        end
        for (int d = 0; d < 2; d++) begin
            rnd = lfsr(rnd);
            host_status_in <= rnd[15:8];
            select_drive_head_reg_in <= {3'h0, d[0], 4'h0};
            wr(d ? IDX_DRV1_STATUS : IDX_DRV0_STATUS, rnd[7:0]);
            rd(d ? IDX_DRV1_STATUS : IDX_DRV0_STATUS, {25'h0, rnd[7:0]});
            wt(3);
            cmp("host_status", {25'h0, host_status_out}, {25'h0, (rnd[15:8] & ~HOST_STATUS_MASK)
                | (rnd[7:0] & HOST_STATUS_MASK)});
        end
        wt(2);
        print_verdict();
    end
endmodule
`default_nettype wire
